// >>> core/bvr_pkg.sv
// Constants shared by the bar code verify router and its reference store.
// Assumes byte streams arrive already deframed from the serial ports.
package bvr_pkg;
	// ==========================================================
	// Table and string sizes
	localparam int          DEPTH    = 399;
	localparam int          IDX_W    = 9;
	localparam int          CHARS    = 16;
	localparam int          STR_W    = CHARS * 8;
	localparam int          LEN_W    = 5;
	localparam int          KEY_W    = LEN_W + STR_W;
	localparam int          WORD_W   = KEY_W + STR_W;
	localparam int          BCD_TEN  = 10;
	localparam int          BCD_HUND = 100;
	localparam logic [IDX_W-1:0] IDX_LAST = 9'h18E;
	localparam logic [LEN_W-1:0] LEN_MAX  = 5'h10;
	// ==========================================================
	// Codes
	localparam logic [7:0] CR_CHAR = 8'h0D;
	localparam logic [1:0] MODE_MULTI  = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_TWO    = 2'h2;
	localparam logic [1:0] FMT_ONEHOT  = 2'h0;
	localparam logic [1:0] FMT_BIN     = 2'h1;
	localparam logic [1:0] FMT_BCD     = 2'h2;
	localparam logic [1:0] DEV_PC      = 2'h0;
	localparam logic [1:0] DEV_PLC     = 2'h1;
	localparam logic [1:0] DEV_PRN     = 2'h2;
	localparam logic [1:0] DEV_RDR     = 2'h3;
	localparam logic [1:0] SRC_RDR     = 2'h0;
	localparam logic [1:0] SRC_KEY     = 2'h1;
	localparam logic [1:0] SRC_HOST    = 2'h2;
endpackage : bvr_pkg

// >>> core/bvr_mem.sv
// Reference string store: key half and substitute half, registered read.
// Assumes one clock; write and read share one address.
`timescale 1ns/100ps
module bvr_mem #(
	parameter int KEY_W  = 133,
	parameter int SUB_W  = 128,
	parameter int DEPTH  = 399,
	parameter int AW     = 9
) (
	input  wire logic                   clk_in,
	input  wire logic                   clk_en_in,
	input  wire logic [AW-1:0]          addr_in,
	input  wire logic                   we_key_in,
	input  wire logic                   we_sub_in,
	input  wire logic [SUB_W+KEY_W-1:0] wdata_in,
	output logic      [SUB_W+KEY_W-1:0] rdata_out
);
	logic [KEY_W-1:0] key_mem [DEPTH];
	logic [SUB_W-1:0] sub_mem [DEPTH];

	always_ff @(posedge clk_in) begin
		if (clk_en_in) begin
			if (we_key_in)
				key_mem[addr_in] <= wdata_in[KEY_W-1:0];
			if (we_sub_in)
				sub_mem[addr_in] <= wdata_in[SUB_W+KEY_W-1:KEY_W];
			rdata_out <= {sub_mem[addr_in], key_mem[addr_in]};
		end
	end
endmodule : bvr_mem

// >>> core/barcode_verify_router.sv
// Data path of a bar code display and verify unit: reader strings in,
// verdicts, parallel result, host/printer/PLC strings out.
// Assumes serial ports are deframed into byte strobes, one byte a cycle.
`timescale 1ns/100ps
// How it works
// - Up to 399 stored strings; in multi mode each reader string is checked against them.
// - On a match in multi mode the entry index goes out as one-hot (entries 0 to 15 only, else all zero), binary or BCD.
// - Single-entry mode checks one chosen entry; OK on match, mismatch otherwise.
// - Two-read mode keeps the first string and compares the next to it.
// - New entries come from reader strings, keypad strings or host commands.
// - Host port as second reader: both ports feed strings alike, source unrecorded.
// - With a second reader on the host port, no host/PLC/printer output except the pass-through relay of reader bytes to the host port.
// - Parallel result goes out one cycle before the first host transmit byte for one readout.
// - Pass-through skips all comparison and leaves parallel outputs idle.
// - Pass-through forwards host bytes to the reader, never executing them.
// - Pass-through relays reader strings unchanged to the host.
// - Pass-through still shows readouts and reader replies on the display.
// - Pass-through disables the PLC memory write.
// - Pass-through frames are text plus one CR, no header.
// - Pass-through uses no ACK/NAK or RTS/CTS toward the reader.
// - Auto print sends each readout to the printer at once.
// - Reference lookup shows the substitute text instead of the readout.
// - PLC link writes each readout straight into PLC data memory.
// - A keypad or second-port string can stand in for a failed read.
module barcode_verify_router #(
	parameter int PAR_W = 16
) (
	input  wire logic                          core_clk_in,
	input  wire logic                          rst_n_in,
	input  wire logic                          clk_en_in,
	input  wire logic                          rdr_valid_in,
	input  wire logic [7:0]                    rdr_byte_in,
	input  wire logic                          host_valid_in,
	input  wire logic [7:0]                    host_byte_in,
	input  wire logic                          key_valid_in,
	input  wire logic [7:0]                    key_byte_in,
	input  wire logic [1:0]                    mode_in,
	input  wire logic [1:0]                    out_fmt_in,
	input  wire logic [1:0]                    host_dev_in,
	input  wire logic                          passthru_in,
	input  wire logic                          auto_print_in,
	input  wire logic                          ref_lookup_in,
	input  wire logic                          plc_link_in,
	input  wire logic                          learn_in,
	input  wire logic                          learn_sub_in,
	input  wire logic [bvr_pkg::IDX_W-1:0]     learn_index_in,
	input  wire logic [bvr_pkg::IDX_W-1:0]     sel_index_in,
	output logic      [PAR_W-1:0]              par_out,
	output logic                               par_valid_out,
	output logic                               ok_out,
	output logic                               mismatch_result_out,
	output logic                               host_tx_valid_out,
	output logic      [7:0]                    host_tx_byte_out,
	output logic                               rdr_tx_valid_out,
	output logic      [7:0]                    rdr_tx_byte_out,
	output logic                               disp_valid_out,
	output logic      [bvr_pkg::STR_W-1:0]     disp_str_out,
	output logic                               plc_wr_valid_out,
	output logic      [bvr_pkg::STR_W-1:0]     plc_wr_str_out,
	output logic                               busy_out
);
	// ==========================================================
	// State
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_LOOK = 5'b00010,
		S_CMP  = 5'b00100,
		S_DONE = 5'b01000,
		S_SEND = 5'b10000
	} state_e;

	typedef struct packed {
		state_e                      st;
		logic [bvr_pkg::STR_W-1:0]   acc;
		logic [bvr_pkg::LEN_W-1:0]   len;
		logic                        fresh;
		logic [1:0]                  src;
		logic [bvr_pkg::STR_W-1:0]   first;
		logic [bvr_pkg::LEN_W-1:0]   first_len;
		logic                        have_first;
		logic [bvr_pkg::IDX_W-1:0]   addr;
		logic                        hit;
		logic [bvr_pkg::IDX_W-1:0]   hit_idx;
		logic [bvr_pkg::STR_W-1:0]   sub;
		logic [bvr_pkg::LEN_W-1:0]   tx_i;
		logic [PAR_W-1:0]            par;
		logic                        par_v;
		logic                        ok;
		logic                        ng;
		logic                        htx_v;
		logic [7:0]                  htx_b;
		logic                        rtx_v;
		logic [7:0]                  rtx_b;
		logic                        disp_v;
		logic [bvr_pkg::STR_W-1:0]   disp;
		logic                        plc_v;
		logic [bvr_pkg::STR_W-1:0]   plc;
		logic                        busy;
	} state_s;

	state_s q;
	state_s next_q;

	logic                         mem_we_key;
	logic                         mem_we_sub;
	logic [bvr_pkg::IDX_W-1:0]    mem_addr;
	logic [bvr_pkg::WORD_W-1:0]   mem_rd;
	logic                         in_v;
	logic [7:0]                   in_b;
	logic [1:0]                   in_src;
	logic                         key_hit;

	// ==========================================================
	// Functions
	function automatic logic [PAR_W-1:0] enc(input logic [bvr_pkg::IDX_W-1:0] i,
	                                         input logic [1:0] f);
		logic [PAR_W-1:0] r;
		r = '0;
		if (f == bvr_pkg::FMT_ONEHOT) begin
			if (int'(i) < PAR_W)
				r = PAR_W'(1'b1) << i;
		end else if (f == bvr_pkg::FMT_BIN) begin
			r = PAR_W'(i);
		end else begin
			r = PAR_W'({4'(int'(i) / bvr_pkg::BCD_HUND),
			            4'((int'(i) / bvr_pkg::BCD_TEN) % bvr_pkg::BCD_TEN),
			            4'(int'(i) % bvr_pkg::BCD_TEN)});
		end
		return r;
	endfunction : enc

	function automatic logic [7:0] char_at(input logic [bvr_pkg::STR_W-1:0] s,
	                                       input logic [bvr_pkg::LEN_W-1:0] k);
		return s[k*8 +: 8];
	endfunction : char_at

	// ==========================================================
	// Reference store
	bvr_mem #(
		.KEY_W (bvr_pkg::KEY_W),
		.SUB_W (bvr_pkg::STR_W),
		.DEPTH (bvr_pkg::DEPTH),
		.AW    (bvr_pkg::IDX_W)
	) u_mem (
		.clk_in    (core_clk_in),
		.clk_en_in (clk_en_in),
		.addr_in   (mem_addr),
		.we_key_in (mem_we_key),
		.we_sub_in (mem_we_sub),
		.wdata_in  ({q.acc, q.len, q.acc}),
		.rdata_out (mem_rd)
	);

	assign mem_addr = (mem_we_key || mem_we_sub) ? learn_index_in : q.addr;
	assign key_hit  = (mem_rd[bvr_pkg::KEY_W-1:0] == {q.len, q.acc});

	// ==========================================================
	// Input arbitration
	always_comb begin
		in_v   = 1'b0;
		in_b   = rdr_byte_in;
		in_src = bvr_pkg::SRC_RDR;
		if (rdr_valid_in) begin
			in_v = 1'b1;
		end else if (host_valid_in) begin
			in_v   = 1'b1;
			in_b   = host_byte_in;
			in_src = (host_dev_in == bvr_pkg::DEV_RDR) ? bvr_pkg::SRC_RDR : bvr_pkg::SRC_HOST;
		end else if (key_valid_in) begin
			in_v   = 1'b1;
			in_b   = key_byte_in;
			in_src = bvr_pkg::SRC_KEY;
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_q        = q;
		next_q.par_v  = 1'b0;
		next_q.htx_v  = 1'b0;
		next_q.rtx_v  = 1'b0;
		next_q.disp_v = 1'b0;
		next_q.plc_v  = 1'b0;
		mem_we_key    = 1'b0;
		mem_we_sub    = 1'b0;
		if (passthru_in) begin
			next_q.st  = S_IDLE;
			next_q.par = '0;
			next_q.ok  = 1'b0;
			next_q.ng  = 1'b0;
			next_q.plc_v = 1'b0;
			if (rdr_valid_in) begin
				next_q.htx_v = 1'b1;
				next_q.htx_b = rdr_byte_in;
				if (rdr_byte_in == bvr_pkg::CR_CHAR) begin
					next_q.disp_v = 1'b1;
					next_q.disp   = q.acc;
					next_q.fresh  = 1'b1;
				end else if (q.fresh) begin
					next_q.acc   = bvr_pkg::STR_W'(rdr_byte_in);
					next_q.len   = bvr_pkg::LEN_W'(1'b1);
					next_q.fresh = 1'b0;
				end else begin
					next_q.acc = {q.acc[bvr_pkg::STR_W-9:0], rdr_byte_in};
				end
			end
			if (host_valid_in) begin
				next_q.rtx_v = 1'b1;
				next_q.rtx_b = host_byte_in;
			end
		end else begin
			case (q.st)
				S_IDLE: begin
					if (in_v && in_b == bvr_pkg::CR_CHAR) begin
						next_q.fresh = 1'b1;
						next_q.src   = in_src;
						if (in_src == bvr_pkg::SRC_HOST || learn_in) begin
							mem_we_key = !(learn_sub_in && in_src == bvr_pkg::SRC_KEY);
							mem_we_sub = learn_sub_in && in_src == bvr_pkg::SRC_KEY;
						end else if (mode_in == bvr_pkg::MODE_TWO) begin
							if (!q.have_first) begin
								next_q.first      = q.acc;
								next_q.first_len  = q.len;
								next_q.have_first = 1'b1;
								next_q.disp_v     = 1'b1;
								next_q.disp       = q.acc;
							end else begin
								next_q.have_first = 1'b0;
								next_q.hit = {q.first_len, q.first} == {q.len, q.acc};
								next_q.sub = '0;
								next_q.st  = S_DONE;
							end
						end else begin
							next_q.addr = (mode_in == bvr_pkg::MODE_SINGLE) ? sel_index_in : '0;
							next_q.st   = S_LOOK;
						end
					end else if (in_v) begin
						if (q.fresh) begin
							next_q.acc   = bvr_pkg::STR_W'(in_b);
							next_q.len   = bvr_pkg::LEN_W'(1'b1);
							next_q.fresh = 1'b0;
						end else begin
							next_q.acc = {q.acc[bvr_pkg::STR_W-9:0], in_b};
							if (q.len != bvr_pkg::LEN_MAX)
								next_q.len = bvr_pkg::LEN_W'(q.len + 1'b1);
						end
					end
				end
				S_LOOK: begin
					next_q.st = S_CMP;
				end
				S_CMP: begin
					if (key_hit) begin
						next_q.hit     = 1'b1;
						next_q.hit_idx = q.addr;
						next_q.sub     = mem_rd[bvr_pkg::WORD_W-1:bvr_pkg::KEY_W];
						next_q.st      = S_DONE;
					end else if (mode_in == bvr_pkg::MODE_SINGLE || q.addr == bvr_pkg::IDX_LAST) begin
						next_q.hit = 1'b0;
						next_q.st  = S_DONE;
					end else begin
						next_q.addr = bvr_pkg::IDX_W'(q.addr + 1'b1);
						next_q.st   = S_LOOK;
					end
				end
				S_DONE: begin
					next_q.ok = q.hit;
					next_q.ng = !q.hit;
					if (mode_in == bvr_pkg::MODE_MULTI && q.hit) begin
						next_q.par   = enc(q.hit_idx, out_fmt_in);
						next_q.par_v = 1'b1;
					end
					next_q.disp_v = 1'b1;
					next_q.disp   = (ref_lookup_in && q.hit && q.sub != '0) ? q.sub : q.acc;
					if (plc_link_in && host_dev_in == bvr_pkg::DEV_PLC) begin
						next_q.plc_v = 1'b1;
						next_q.plc   = q.acc;
					end
					next_q.tx_i = q.len;
					if (host_dev_in == bvr_pkg::DEV_PC
					    || (host_dev_in == bvr_pkg::DEV_PRN && auto_print_in))
						next_q.st = S_SEND;
					else
						next_q.st = S_IDLE;
				end
				S_SEND: begin
					if (host_dev_in == bvr_pkg::DEV_RDR) begin
						next_q.st = S_IDLE;
					end else if (q.tx_i != '0) begin
						next_q.htx_v = 1'b1;
						next_q.htx_b = char_at(q.acc, bvr_pkg::LEN_W'(q.tx_i - 1'b1));
						next_q.tx_i  = bvr_pkg::LEN_W'(q.tx_i - 1'b1);
					end else begin
						next_q.htx_v = 1'b1;
						next_q.htx_b = bvr_pkg::CR_CHAR;
						next_q.st    = S_IDLE;
					end
				end
				default: next_q.st = S_IDLE;
			endcase
		end
		next_q.busy = (next_q.st != S_IDLE);
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q       <= '0;
			q.st    <= S_IDLE;
			q.fresh <= 1'b1;
		end else if (clk_en_in) begin
			q <= next_q;
		end
	end

	// ==========================================================
	// Outputs
	assign par_out             = q.par;
	assign par_valid_out       = q.par_v;
	assign ok_out              = q.ok;
	assign mismatch_result_out = q.ng;
	assign host_tx_valid_out   = q.htx_v;
	assign host_tx_byte_out    = q.htx_b;
	assign rdr_tx_valid_out    = q.rtx_v;
	assign rdr_tx_byte_out     = q.rtx_b;
	assign disp_valid_out      = q.disp_v;
	assign disp_str_out        = q.disp;
	assign plc_wr_valid_out    = q.plc_v;
	assign plc_wr_str_out      = q.plc;
	assign busy_out            = q.busy;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_pass_relay;
		passthru_in && clk_en_in && rdr_valid_in |=>
			host_tx_valid_out && host_tx_byte_out == $past(rdr_byte_in);
	endproperty
	a_pass_relay: assert property (p_pass_relay) else $error("reader byte not relayed");

	property p_pass_cmd;
		passthru_in && clk_en_in && host_valid_in |=>
			rdr_tx_valid_out && rdr_tx_byte_out == $past(host_byte_in);
	endproperty
	a_pass_cmd: assert property (p_pass_cmd) else $error("host command not forwarded");

	property p_pass_nopar;
		passthru_in && clk_en_in |=> !par_valid_out && par_out == '0 && !ok_out;
	endproperty
	a_pass_nopar: assert property (p_pass_nopar) else $error("parallel driven in pass-through");

	property p_pass_noplc;
		passthru_in && clk_en_in |=> !plc_wr_valid_out;
	endproperty
	a_pass_noplc: assert property (p_pass_noplc) else $error("PLC write in pass-through");

	property p_rdr2_quiet;
		!passthru_in && host_dev_in == bvr_pkg::DEV_RDR && clk_en_in |=> !host_tx_valid_out;
	endproperty
	a_rdr2_quiet: assert property (p_rdr2_quiet) else $error("host tx with second reader");

	property p_verdict;
		!passthru_in && clk_en_in && q.st == S_DONE |=> ok_out != mismatch_result_out;
	endproperty
	a_verdict: assert property (p_verdict) else $error("verdict not exclusive");

	property p_par_enc;
		!passthru_in && clk_en_in && q.st == S_DONE && q.hit && mode_in == bvr_pkg::MODE_MULTI
		|=> par_valid_out && par_out == enc($past(q.hit_idx), $past(out_fmt_in)) && ok_out;
	endproperty
	a_par_enc: assert property (p_par_enc) else $error("parallel index wrong");

	property p_send_cr;
		!passthru_in && clk_en_in && q.st == S_SEND && q.tx_i == '0
		&& host_dev_in != bvr_pkg::DEV_RDR |=>
			host_tx_valid_out && host_tx_byte_out == bvr_pkg::CR_CHAR && !busy_out;
	endproperty
	a_send_cr: assert property (p_send_cr) else $error("string not closed by CR");

	c_relay: cover property (passthru_in && rdr_valid_in ##1 host_tx_valid_out);
	c_multi_hit: cover property (par_valid_out && ok_out);
	c_two_read: cover property (mode_in == bvr_pkg::MODE_TWO && ok_out);
	c_send_end: cover property (host_tx_valid_out && host_tx_byte_out == bvr_pkg::CR_CHAR);
endmodule : barcode_verify_router

// >>> verif/rdr_model.sv
// Serial bar code reader model on the far side of the reader port.
// Assumes byte strobes already deframed, one byte per clock at most.
`timescale 1ns/100ps
module rdr_model (
	input  wire logic       clk_in,
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_byte_in,
	output logic            valid_out,
	output logic [7:0]      byte_out
);
	logic [127:0] rx_hist;
	int           rx_cnt;

	initial begin
		valid_out = 1'b0;
		byte_out = 8'hFF;
		rx_hist = '0;
		rx_cnt = 0;
	end

	// ==========================================================
	// Readout strings
	// text then one CR
	// no ack or flow control lines
	task automatic send(input string s);
		int i;
		for (i = 0; i <= s.len(); i++) begin
			@(posedge clk_in);
			#1;
			valid_out = 1'b1;
			byte_out = (i == s.len()) ? 8'h0D : s[i];
		end
		@(posedge clk_in);
		#1;
		valid_out = 1'b0;
		byte_out = ~byte_out;
	endtask : send

	// ==========================================================
	// Commands forwarded by the device
	always @(posedge clk_in) begin
		if (tx_valid_in === 1'b1) begin
			rx_hist <= {rx_hist[119:0], tx_byte_in};
			rx_cnt <= rx_cnt + 1;
		end
	end
endmodule : rdr_model

// >>> verif/tb_top.sv
// Self-checking bench for the bar code verify router.
// Assumes the reader model on the reader port; host and keypad driven here.
`timescale 1ns/100ps
module tb_top;
	logic                         core_clk_in, rst_n_in, host_valid_in, key_valid_in;
	logic [7:0]                   host_byte_in, key_byte_in, rdr_byte_in;
	logic                         rdr_valid_in, passthru_in, auto_print_in, clk_en_in;
	logic                         ref_lookup_in, plc_link_in, learn_in, learn_sub_in;
	logic [1:0]                   mode_in, out_fmt_in, host_dev_in;
	logic [bvr_pkg::IDX_W-1:0]    learn_index_in, sel_index_in;
	logic [15:0]                  par_out;
	logic                         par_valid_out, ok_out, mismatch_result_out, busy_out;
	logic                         host_tx_valid_out, rdr_tx_valid_out, disp_valid_out;
	logic [7:0]                   host_tx_byte_out, rdr_tx_byte_out;
	logic [bvr_pkg::STR_W-1:0]    disp_str_out, plc_wr_str_out;
	logic                         plc_wr_valid_out;
	logic [127:0]                 htx;
	int                           n_htx, n_par, n_plc, n_disp;
	int                           n_mismatch, compares;

	barcode_verify_router #(.PAR_W(16)) dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in), .rdr_valid_in(rdr_valid_in), .rdr_byte_in(rdr_byte_in),
		.host_valid_in(host_valid_in), .host_byte_in(host_byte_in),
		.key_valid_in(key_valid_in), .key_byte_in(key_byte_in), .mode_in(mode_in),
		.out_fmt_in(out_fmt_in), .host_dev_in(host_dev_in), .passthru_in(passthru_in),
		.auto_print_in(auto_print_in), .ref_lookup_in(ref_lookup_in),
		.plc_link_in(plc_link_in), .learn_in(learn_in), .learn_sub_in(learn_sub_in),
		.learn_index_in(learn_index_in), .sel_index_in(sel_index_in), .par_out(par_out),
		.par_valid_out(par_valid_out), .ok_out(ok_out),
		.mismatch_result_out(mismatch_result_out), .host_tx_valid_out(host_tx_valid_out),
		.host_tx_byte_out(host_tx_byte_out), .rdr_tx_valid_out(rdr_tx_valid_out),
		.rdr_tx_byte_out(rdr_tx_byte_out), .disp_valid_out(disp_valid_out),
		.disp_str_out(disp_str_out), .plc_wr_valid_out(plc_wr_valid_out),
		.plc_wr_str_out(plc_wr_str_out), .busy_out(busy_out));

	rdr_model u_rdr (.clk_in(core_clk_in), .tx_valid_in(rdr_tx_valid_out),
		.tx_byte_in(rdr_tx_byte_out), .valid_out(rdr_valid_in), .byte_out(rdr_byte_in));

	// ==========================================================
	// Output monitors
	always @(posedge core_clk_in) begin
		if (host_tx_valid_out === 1'b1) begin
			htx <= {htx[119:0], host_tx_byte_out};
			n_htx <= n_htx + 1;
		end
		if (par_valid_out === 1'b1) n_par <= n_par + 1;
		if (plc_wr_valid_out === 1'b1) n_plc <= n_plc + 1;
		if (disp_valid_out === 1'b1) n_disp <= n_disp + 1;
	end

	// ==========================================================
	// Helpers
	function automatic logic [127:0] str_vec(input string s);
		logic [127:0] v;
		v = '0;
		for (int i = 0; i < s.len(); i++)
			v = {v[119:0], s[i]};
		return v;
	endfunction : str_vec

	function automatic logic [127:0] frame(input string s);
		logic [127:0] v;
		v = str_vec(s);
		return {v[119:0], 8'h0D};
	endfunction : frame

	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic host_send(input string s);
		int i;
		for (i = 0; i <= s.len(); i++) begin
			@(posedge core_clk_in);
			#1;
			host_valid_in = 1'b1;
			host_byte_in = (i == s.len()) ? 8'h0D : s[i];
		end
		@(posedge core_clk_in);
		#1;
		host_valid_in = 1'b0;
		host_byte_in = ~host_byte_in;
	endtask : host_send

	task automatic key_send(input string s);
		int i;
		for (i = 0; i <= s.len(); i++) begin
			@(posedge core_clk_in);
			#1;
			key_valid_in = 1'b1;
			key_byte_in = (i == s.len()) ? 8'h0D : s[i];
		end
		@(posedge core_clk_in);
		#1;
		key_valid_in = 1'b0;
		key_byte_in = ~key_byte_in;
	endtask : key_send

	task automatic settle();
		int n;
		n = 0;
		@(posedge core_clk_in);
		#1;
		while (busy_out !== 1'b0 && n < 2000) begin
			@(posedge core_clk_in);
			#1;
			n++;
		end
		if (n >= 2000) chk(busy_out, 1'b0);
		repeat (3) @(posedge core_clk_in);
		#1;
	endtask : settle

	task automatic clear_mon();
		htx = '0;
		n_htx = 0;
		n_par = 0;
		n_plc = 0;
		n_disp = 0;
	endtask : clear_mon

	task automatic verdict(input logic ok_e);
		chk(ok_out, ok_e);
		chk(mismatch_result_out, !ok_e);
	endtask : verdict

	// ==========================================================
	// Scenarios
	task automatic t_learn();
		learn_in = 1'b1;
		learn_index_in = 9'h005;
		u_rdr.send("AB");
		settle();
		learn_index_in = 9'h00C;
		u_rdr.send("MN");
		settle();
		learn_in = 1'b0;
	endtask : t_learn

	task automatic t_single();
		mode_in = bvr_pkg::MODE_SINGLE;
		sel_index_in = 9'h005;
		clear_mon();
		u_rdr.send("AB");
		settle();
		verdict(1'b1);
		chk(htx, frame("AB"));
		chk(n_htx, 3);
		chk(disp_str_out, str_vec("AB"));
		host_dev_in = bvr_pkg::DEV_PLC;
		plc_link_in = 1'b1;
		clear_mon();
		u_rdr.send("AC");
		settle();
		verdict(1'b0);
		chk(n_plc, 1);
		chk(plc_wr_str_out, str_vec("AC"));
		plc_link_in = 1'b0;
		host_dev_in = bvr_pkg::DEV_PC;
	endtask : t_single

	task automatic t_multi();
		logic [1:0]  fmt [3];
		logic [15:0] exp [3];
		int          k;
		fmt = '{bvr_pkg::FMT_ONEHOT, bvr_pkg::FMT_BIN, bvr_pkg::FMT_BCD};
		exp = '{16'h1000, 16'h000C, 16'h0012};
		mode_in = bvr_pkg::MODE_MULTI;
		for (k = 0; k < 3; k++) begin
			out_fmt_in = fmt[k];
			clear_mon();
			u_rdr.send("MN");
			settle();
			chk(n_par, 1);
			chk(par_out, exp[k]);
			chk(htx, frame("MN"));
		end
	endtask : t_multi

	task automatic t_two();
		mode_in = bvr_pkg::MODE_TWO;
		u_rdr.send("XY");
		settle();
		u_rdr.send("XY");
		settle();
		verdict(1'b1);
		u_rdr.send("XY");
		settle();
		u_rdr.send("XZ");
		settle();
		verdict(1'b0);
	endtask : t_two

	task automatic t_host_store();
		mode_in = bvr_pkg::MODE_SINGLE;
		learn_index_in = 9'h007;
		clear_mon();
		host_send("HQ");
		settle();
		chk(n_htx, 0);
		sel_index_in = 9'h007;
		u_rdr.send("HQ");
		settle();
		verdict(1'b1);
	endtask : t_host_store

	task automatic t_key();
		mode_in = bvr_pkg::MODE_SINGLE;
		sel_index_in = 9'h005;
		learn_index_in = 9'h005;
		learn_in = 1'b1;
		learn_sub_in = 1'b1;
		key_send("ok");
		settle();
		learn_in = 1'b0;
		learn_sub_in = 1'b0;
		ref_lookup_in = 1'b1;
		auto_print_in = 1'b1;
		host_dev_in = bvr_pkg::DEV_PRN;
		clear_mon();
		key_send("AB");
		settle();
		verdict(1'b1);
		chk(disp_str_out, str_vec("ok"));
		chk(htx, frame("AB"));
		ref_lookup_in = 1'b0;
		auto_print_in = 1'b0;
		host_dev_in = bvr_pkg::DEV_PC;
	endtask : t_key

	task automatic t_second_rdr();
		host_dev_in = bvr_pkg::DEV_RDR;
		sel_index_in = 9'h005;
		clear_mon();
		host_send("AB");
		settle();
		verdict(1'b1);
		u_rdr.send("AC");
		settle();
		verdict(1'b0);
		chk(n_htx, 0);
		host_dev_in = bvr_pkg::DEV_PC;
	endtask : t_second_rdr

	task automatic t_pass();
		passthru_in = 1'b1;
		plc_link_in = 1'b1;
		host_dev_in = bvr_pkg::DEV_PLC;
		clear_mon();
		u_rdr.rx_cnt = 0;
		repeat (2) @(posedge core_clk_in);
		#1;
		chk(ok_out, 1'b0);
		chk(mismatch_result_out, 1'b0);
		clk_en_in = 1'b0;
		u_rdr.send("Z");
		chk(n_htx, 0);
		clk_en_in = 1'b1;
		u_rdr.send("Q");
		settle();
		chk(htx, frame("Q"));
		chk(disp_str_out, str_vec("Q"));
		chk(n_htx, 2);
		host_send("C");
		settle();
		chk(u_rdr.rx_hist[15:0], frame("C"));
		chk(u_rdr.rx_cnt, 2);
		chk(n_par, 0);
		chk(n_plc, 0);
		chk(n_disp > 0, 1'b1);
		passthru_in = 1'b0;
		plc_link_in = 1'b0;
		host_dev_in = bvr_pkg::DEV_PC;
	endtask : t_pass

	// ==========================================================
	// Closing
	task automatic results();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	initial begin
		repeat (50000) @(posedge core_clk_in);
		n_mismatch++;
		results();
	end

	initial begin
		{host_valid_in, key_valid_in, passthru_in, auto_print_in} = '0;
		{ref_lookup_in, plc_link_in, learn_in, learn_sub_in} = '0;
		{host_byte_in, key_byte_in} = '0;
		mode_in = bvr_pkg::MODE_MULTI;
		out_fmt_in = bvr_pkg::FMT_BIN;
		host_dev_in = bvr_pkg::DEV_PC;
		{learn_index_in, sel_index_in} = '0;
		clk_en_in = 1'b1;
		n_mismatch = 0;
		compares = 0;
		clear_mon();
		rst_n_in = 1'b0;
		repeat (12) @(posedge core_clk_in);
		#1;
		rst_n_in = 1'b1;
		t_learn();
		t_single();
		t_multi();
		t_two();
		t_host_store();
		t_key();
		t_second_rdr();
		t_pass();
		results();
	end
endmodule : tb_top
